/* rtl/tcbu_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "tcbu_map.vh"
// transfer control unit: jump, call, return, interrupt
module tcbu_top
(
   // clock and reset
   input wire MCLK,
   input wire RSTN,
   // instruction issue from fetch engine
   input wire INSTR_VALID,
   input wire [31:0] INSTR_WORD0,
   input wire [31:0] INSTR_WORD1,
   output wire INSTR_READY,
   output reg INSTR_DONE,
   // fetch engine advances pointer per longword
   input wire FETCH_STEP,
   // datapath status from same clock domain
   input wire CARRY,
   input wire INITIATOR_MODE,
   input wire NEW_PHASE,
   input wire [7:0] FIRST_BYTE,
   // scsi pins, asynchronous
   input wire SCSI_MSG,
   input wire SCSI_CD,
   input wire SCSI_IO,
   input wire SCSI_REQ,
   input wire SCSI_ATN,
   // host side
   input wire HOST_PTR_WE,
   input wire [31:0] HOST_PTR_WDATA,
   input wire HOST_FLY_CLR,
   output wire IRQ_N,
   output wire HALTED,
   output wire [31:0] INSTR_PTR,
   output wire [31:0] SAVE_PTR,
   output wire [31:0] OPERAND,
   output wire [7:0] INT_STATUS,
   output wire [2:0] PHASE_LATCHED
);
   // states: idle takes work, exec decides in one cycle,
   // wait parks for a phase, halt waits for the host
   localparam ST_IDLE = 2'h0; // ready for the next instruction
   localparam ST_WAIT = 2'h1; // stalled until a fresh phase
   localparam ST_EXEC = 2'h2; // condition and target settle here
   localparam ST_HALT = 2'h3; // stopped until a pointer write

   // pin synchronisers, first stage read only by second;
   // REQ costs three edges from pin to the phase latch
   reg [4:0] pin_s1_reg;
   reg [4:0] pin_s2_reg;
   reg req_prev_reg; // for REQ edge
   reg [2:0] phase_reg; // phase lines caught on REQ
   wire req_rise;
   wire atn_sync;

   // architectural state
   reg [31:0] ptr_reg; // instruction pointer
   reg [31:0] ptr_next;
   reg [31:0] save_reg; // call/return save
   reg [31:0] save_next;
   reg [31:0] instruction_operand_reg;
   reg [31:0] instr_reg; // held first longword
   reg [7:0] interrupt_status_reg;
   reg [7:0] status_next;
   reg irq_reg;
   reg irq_next;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg done_next;
   reg wait_seen_reg; // awaited phase has arrived
   reg fly_event; // on-the-fly flag raised this cycle

   // decode
   wire [2:0] opcode;
   wire taken;
   wire [31:0] target;
   wire needs_wait;

   // two-flop sync of the bus pins, then REQ edge;
   // the pins move with no regard to MCLK, so only the
   // second stage feeds any logic
   always @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         pin_s1_reg <= 5'h00;
         pin_s2_reg <= 5'h00;
         req_prev_reg <= 1'b0;
         phase_reg <= 3'h0;
      end
      else
      begin
         pin_s1_reg <= {SCSI_ATN, SCSI_REQ, SCSI_MSG, SCSI_CD, SCSI_IO};
         pin_s2_reg <= pin_s1_reg;
         req_prev_reg <= pin_s2_reg[3];
         // latch phase as REQ goes active; the lines are as
         // old as REQ, so they have settled by then
         if (req_rise)
            phase_reg <= pin_s2_reg[2:0];
      end
   end

   // previous level resets low like an idle pin, so no
   // false edge follows reset
   assign req_rise = pin_s2_reg[3] & ~req_prev_reg;
   // target mode reads ATN as a plain level
   assign atn_sync = pin_s2_reg[4];

   // bits 31-30 are left to the fetch engine to check
   assign opcode = instr_reg[`TCBU_OPC_HI:`TCBU_OPC_LO];

   // only phase or data compares wait for a fresh phase;
   // a carry test stalls only when a compare bit is set too
   assign needs_wait = instr_reg[`TCBU_WAIT_BIT]
      && (instr_reg[`TCBU_PCMP_BIT] || instr_reg[`TCBU_DCMP_BIT]);

   // condition evaluator; datapath inputs share MCLK
   // and need no synchroniser
   tcbu_cond u_cond
   (
      .instr(instr_reg),
      .carry(CARRY),
      .initiator(INITIATOR_MODE),
      .atn(atn_sync),
      .phase_latched(phase_reg),
      .first_byte(FIRST_BYTE),
      .taken(taken)
   );

   // branch target; a relative jump trusts the fetch engine
   // to have stepped the pointer past both longwords
   tcbu_target u_target
   (
      .opcode(opcode),
      .rel(instr_reg[`TCBU_REL_BIT]),
      .ptr(ptr_reg),
      .operand(instruction_operand_reg),
      .target(target)
   );

   // next-state and datapath decisions, in one process so
   // that a host write can override whatever the state
   // machine chose in the same cycle
   always @*
   begin
      state_next = state_reg;
      fly_event = 1'b0;
      ptr_next = ptr_reg;
      save_next = save_reg;
      status_next = interrupt_status_reg;
      irq_next = irq_reg;
      done_next = 1'b0;
      // each fetched longword moves the pointer on
      if (FETCH_STEP)
         ptr_next = ptr_reg + `TCBU_PTR_STEP;
      case (state_reg)
         ST_IDLE:
         begin
            // a host write in the same cycle cancels the take
            if (INSTR_VALID)
               state_next = ST_EXEC;
         end
         ST_WAIT:
         begin
            // compare only once a new phase shows up
            // a host write is the only other way out
            if (NEW_PHASE)
               state_next = ST_EXEC;
         end
         ST_EXEC:
         begin
            if (instr_reg[`TCBU_OPC_HI])
            begin
               // reserved opcode: stop and flag; no guess is made at
               // what the code was meant to do
               status_next[`TCBU_ST_ILLEGAL] = 1'b1;
               irq_next = 1'b1;
               state_next = ST_HALT;
               done_next = 1'b1;
            end
            // a phase already fresh in this cycle needs no stall
            else if (needs_wait && !NEW_PHASE && !wait_seen_reg)
               state_next = ST_WAIT;
            else if (!taken)
            begin
               // pointer already holds the next address; a fetch
               // step in this cycle still applies
               state_next = ST_IDLE;
               done_next = 1'b1;
            end
            else
            begin
               done_next = 1'b1;
               state_next = ST_IDLE;
               case (opcode)
                  `TCBU_OP_JUMP:
                     ptr_next = target;
                  `TCBU_OP_CALL:
                  begin
                     // the pointer already names the return point
                     save_next = ptr_reg;
                     ptr_next = target;
                  end
                  `TCBU_OP_RET:
                     // no check for a matching call; without one the
                     // save register just gives its last value
                     ptr_next = save_reg;
                  `TCBU_OP_INT:
                  begin
                     if (instr_reg[`TCBU_FLY_BIT])
                     begin
                        status_next[`TCBU_ST_FLY] = 1'b1;
                        fly_event = 1'b1;
                     end
                     else
                     begin
                        // request holds until the host writes the pointer
                        irq_next = 1'b1;
                        state_next = ST_HALT;
                     end
                  end
                  default:
                     state_next = ST_IDLE;
               endcase
            end
         end
         ST_HALT:
         begin
            // only a host pointer write restarts; the vector
            // stays readable the whole time
            state_next = ST_HALT;
         end
         default:
            // unused code falls back to idle
            state_next = ST_IDLE;
      endcase

      // host clear of the fly bit; a set in the same cycle
      // wins, even over a flag that was already up
      if (HOST_FLY_CLR && !fly_event)
         status_next[`TCBU_ST_FLY] = 1'b0;

      // host pointer write overrides pointer, request, illegal flag and state, and resumes;
      // the fly flag keeps its own clear
      if (HOST_PTR_WE)
      begin
         ptr_next = HOST_PTR_WDATA;
         irq_next = 1'b0;
         status_next[`TCBU_ST_ILLEGAL] = 1'b0;
         state_next = ST_IDLE;
      end
   end

   // registers; the held longwords only change on a take,
   // so the vector survives a halt for the host to read
   always @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         // all clear: request released, unit ready
         state_reg <= ST_IDLE;
         ptr_reg <= `TCBU_PTR_RST;
         save_reg <= `TCBU_PTR_RST;
         instruction_operand_reg <= `TCBU_PTR_RST;
         instr_reg <= `TCBU_PTR_RST;
         interrupt_status_reg <= `TCBU_ST_RST;
         irq_reg <= 1'b0;
         INSTR_DONE <= 1'b0;
         wait_seen_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         ptr_reg <= ptr_next;
         save_reg <= save_next;
         interrupt_status_reg <= status_next;
         irq_reg <= irq_next;
         INSTR_DONE <= done_next;
         // lasts one cycle: exec uses it at once
         wait_seen_reg <= (state_reg == ST_WAIT) && NEW_PHASE;
         // capture both longwords on acceptance; a host
         // write in the same cycle wins over the take
         if (state_reg == ST_IDLE && INSTR_VALID && !HOST_PTR_WE)
         begin
            instr_reg <= INSTR_WORD0;
            // address field stays readable as vector
            instruction_operand_reg <= INSTR_WORD1;
         end
      end
   end

   // outputs: data straight from flip-flops, ready is a
   // plain state decode
   assign INSTR_READY = (state_reg == ST_IDLE);
   // low from the halting edge until the host write
   assign IRQ_N = ~irq_reg;
   assign HALTED = (state_reg == ST_HALT);
   assign INSTR_PTR = ptr_reg;
   assign SAVE_PTR = save_reg;
   assign OPERAND = instruction_operand_reg;
   assign INT_STATUS = interrupt_status_reg;
   assign PHASE_LATCHED = phase_reg;
endmodule // tcbu_top
`default_nettype wire

/* rtl/tcbu_map.vh */
`ifndef TCBU_MAP_VH
`define TCBU_MAP_VH
// first longword fields
`define TCBU_OPC_HI 29
`define TCBU_OPC_LO 27
`define TCBU_PHASE_HI 26
`define TCBU_PHASE_LO 24
`define TCBU_REL_BIT 23
`define TCBU_CARRY_BIT 21
`define TCBU_FLY_BIT 20
`define TCBU_TF_BIT 19
`define TCBU_DCMP_BIT 18
`define TCBU_PCMP_BIT 17
`define TCBU_WAIT_BIT 16
`define TCBU_MASK_HI 15
`define TCBU_MASK_LO 8
`define TCBU_VAL_HI 7
`define TCBU_VAL_LO 0
`define TCBU_OFS_HI 23
// opcodes
`define TCBU_OP_JUMP 3'h0
`define TCBU_OP_CALL 3'h1
`define TCBU_OP_RET 3'h2
`define TCBU_OP_INT 3'h3
// interrupt status bits
`define TCBU_ST_ILLEGAL 0
`define TCBU_ST_FLY 2
// reset values and pointer step
`define TCBU_PTR_RST 32'h00000000
`define TCBU_ST_RST 8'h00
`define TCBU_PTR_STEP 32'h00000004
`endif

/* rtl/tcbu_cond.v */
`timescale 1ns/1ps
`default_nettype none
`include "tcbu_map.vh"
// branch condition evaluator, purely combinational
module tcbu_cond
(
   // instruction and flags
   input wire [31:0] instr,
   input wire carry,
   input wire initiator,
   input wire atn,
   input wire [2:0] phase_latched,
   input wire [7:0] first_byte,
   // result
   output reg taken
);
   reg phase_true; // phase or ATN test outcome
   reg data_true; // masked byte match
   reg tf; // polarity
   always @*
   begin
      tf = instr[`TCBU_TF_BIT];
      // target mode tests ATN instead of phase
      phase_true = initiator ?
         (phase_latched == instr[`TCBU_PHASE_HI:`TCBU_PHASE_LO]) : atn;
      // set mask bits drop the bit from the match
      data_true = (((first_byte ^ instr[`TCBU_VAL_HI:`TCBU_VAL_LO])
         & ~instr[`TCBU_MASK_HI:`TCBU_MASK_LO]) == 8'h00);
      if (instr[`TCBU_CARRY_BIT])
         taken = tf ? carry : ~carry;
      else if (instr[`TCBU_PCMP_BIT] && instr[`TCBU_DCMP_BIT])
         taken = tf ? (phase_true & data_true) : (~phase_true & ~data_true);
      else if (instr[`TCBU_PCMP_BIT])
         taken = tf ? phase_true : ~phase_true;
      else if (instr[`TCBU_DCMP_BIT])
         taken = tf ? data_true : ~data_true;
      else
         taken = 1'b1; // no test selected: always taken
   end
endmodule // tcbu_cond
`default_nettype wire

/* rtl/tcbu_target.v */
`timescale 1ns/1ps
`default_nettype none
`include "tcbu_map.vh"
// branch target: absolute operand or pointer-relative
module tcbu_target
(
   // inputs
   input wire [2:0] opcode,
   input wire rel,
   input wire [31:0] ptr,
   input wire [31:0] operand,
   // result
   output wire [31:0] target
);
   wire [31:0] ofs; // sign-extended 24-bit offset
   wire rel_ok; // relative only for jump and call
   assign ofs = {{8{operand[`TCBU_OFS_HI]}}, operand[`TCBU_OFS_HI:0]};
   assign rel_ok = rel && ((opcode == `TCBU_OP_JUMP) || (opcode == `TCBU_OP_CALL));
   // pointer already addresses the following instruction
   assign target = rel_ok ? (ptr + ofs) : operand;
endmodule // tcbu_target
`default_nettype wire

/* test/tcbu_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// port-level checker for the transfer control unit
module tcbu_check
(
   // clock and reset
   input wire logic MCLK,
   input wire logic RSTN,
   // issue and host side
   input wire logic INSTR_VALID,
   input wire logic INSTR_READY,
   input wire logic INSTR_DONE,
   input wire logic [31:0] INSTR_WORD0,
   input wire logic FETCH_STEP,
   input wire logic HOST_PTR_WE,
   input wire logic [31:0] HOST_PTR_WDATA,
   // results
   input wire logic IRQ_N,
   input wire logic HALTED,
   input wire logic [31:0] INSTR_PTR,
   input wire logic [31:0] SAVE_PTR,
   input wire logic [7:0] INT_STATUS
);
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RSTN);
   // take without the wait bit, so no phase stall
   sequence s_take;
      INSTR_VALID && INSTR_READY && !HOST_PTR_WE && !INSTR_WORD0[16];
   endsequence
   // one busy cycle, then the done pulse
   sequence s_exec;
      !INSTR_READY ##1 INSTR_DONE;
   endsequence
   AST_TAKE_DONE: assert property (s_take |=> s_exec)
      else $error("done not two cycles after take");
   AST_HOST_LOAD: assert property (HOST_PTR_WE |=> INSTR_PTR == $past(HOST_PTR_WDATA) && IRQ_N)
      else $error("host pointer write ignored");
   AST_IRQ_HALT: assert property ($fell(IRQ_N) |-> HALTED)
      else $error("request without halt");
   AST_HALT_HOLD: assert property (HALTED && !HOST_PTR_WE |=> HALTED)
      else $error("left halt without pointer write");
   AST_STEP: assert property (FETCH_STEP && INSTR_READY && !HOST_PTR_WE |=> INSTR_PTR == $past(INSTR_PTR) + 32'h4)
      else $error("fetch step not plus four");
   AST_SAVE_CALL: assert property ($changed(SAVE_PTR) |-> INSTR_DONE)
      else $error("save pointer moved outside an instruction");
   AST_PTR_CAUSE: assert property ($changed(INSTR_PTR) |-> $past(FETCH_STEP) || $past(HOST_PTR_WE) || INSTR_DONE)
      else $error("pointer moved without cause");
   AST_FLY_SET: assert property ($rose(INT_STATUS[2]) |-> INSTR_DONE && IRQ_N && !HALTED)
      else $error("fly flag with halt or request");
   AST_ILLEGAL: assert property ($rose(INT_STATUS[0]) |-> HALTED && !IRQ_N)
      else $error("illegal flag without halt");
endmodule // tcbu_check
bind tcbu_top tcbu_check chk_u (.MCLK(MCLK), .RSTN(RSTN), .INSTR_VALID(INSTR_VALID),
   .INSTR_READY(INSTR_READY), .INSTR_DONE(INSTR_DONE), .INSTR_WORD0(INSTR_WORD0),
   .FETCH_STEP(FETCH_STEP), .HOST_PTR_WE(HOST_PTR_WE), .HOST_PTR_WDATA(HOST_PTR_WDATA),
   .IRQ_N(IRQ_N), .HALTED(HALTED), .INSTR_PTR(INSTR_PTR), .SAVE_PTR(SAVE_PTR),
   .INT_STATUS(INT_STATUS));
`default_nettype wire

/* test/tcbu_host.sv */
`timescale 1ns/1ps
`default_nettype none
// host: answers a request by reloading the pointer
module tcbu_host
#(
   parameter [31:0] RESUME = 32'h00000800
)
(
   // clock and request
   input wire logic MCLK,
   input wire logic IRQ_N,
   // pointer write
   output logic HOST_PTR_WE,
   output logic [31:0] HOST_PTR_WDATA
);
   // idle bus never shows a usable value
   initial
   begin
      HOST_PTR_WE = 1'b0;
      HOST_PTR_WDATA = 32'hFFFFFFFF;
   end
   // slow service: five clocks of delay, then resume
   always @(negedge IRQ_N)
   begin
      repeat (5) @(posedge MCLK);
      #1 HOST_PTR_WE = 1'b1;
      HOST_PTR_WDATA = RESUME;
      @(posedge MCLK) #1 HOST_PTR_WE = 1'b0;
      HOST_PTR_WDATA = ~RESUME;
   end
endmodule // tcbu_host
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   // row: words, carry, first byte, expected pointer and save
   typedef struct {logic [31:0] a, b; logic c; logic [7:0] f; logic [31:0] p, s;} tcbu_row_t;
   tcbu_row_t rows [13] = '{
      '{32'h90000000, 32'h0, 1'h0, 8'h0, 32'h0, 32'h0},
      '{32'h80000000, 32'h2000, 1'h0, 8'h0, 32'h2000, 32'h0},
      '{32'h80280000, 32'h3000, 1'h1, 8'h0, 32'h3000, 32'h0},
      '{32'h80280000, 32'h4000, 1'h0, 8'h0, 32'h3000, 32'h0},
      '{32'h80200000, 32'h4000, 1'h0, 8'h0, 32'h4000, 32'h0},
      '{32'h800C7F80, 32'h5000, 1'h0, 8'h85, 32'h5000, 32'h0},
      '{32'h800C7F80, 32'h6000, 1'h0, 8'h05, 32'h5000, 32'h0},
      '{32'h80800000, 32'hFFFFF0, 1'h0, 8'h0, 32'h4FF0, 32'h0},
      '{32'h88800000, 32'h10, 1'h0, 8'h0, 32'h5000, 32'h4FF0},
      '{32'h88280000, 32'h7000, 1'h0, 8'h0, 32'h5000, 32'h4FF0},
      '{32'h90800000, 32'h123, 1'h0, 8'h0, 32'h4FF0, 32'h4FF0},
      '{32'h800E0000, 32'h8000, 1'h0, 8'h0, 32'h8000, 32'h4FF0},
      '{32'h80060000, 32'h8100, 1'h0, 8'h01, 32'h8000, 32'h4FF0}};
   // stimulus
   logic MCLK = 0, RSTN = 0, vld = 0, carry = 0, init = 1, np = 0, stp = 0, fclr = 0;
   logic msg = 0, cd = 0, io = 0, req = 0, atn = 0;
   logic [31:0] w0 = 0, w1 = 0;
   logic [7:0] fb = 0;
   // observed
   wire logic rdy, done, irq_n, halted, we;
   wire logic [31:0] ptr, save, opnd, wd;
   wire logic [7:0] st;
   wire logic [2:0] ph;
   int fails = 0, checks_done = 0;
   int waited = 0; // ticks the last bounded wait took
   always #2 MCLK = ~MCLK;
   tcbu_top dut_u (.MCLK(MCLK), .RSTN(RSTN), .INSTR_VALID(vld), .INSTR_WORD0(w0),
      .INSTR_WORD1(w1), .INSTR_READY(rdy), .INSTR_DONE(done), .FETCH_STEP(stp),
      .CARRY(carry), .INITIATOR_MODE(init), .NEW_PHASE(np), .FIRST_BYTE(fb),
      .SCSI_MSG(msg), .SCSI_CD(cd), .SCSI_IO(io), .SCSI_REQ(req), .SCSI_ATN(atn),
      .HOST_PTR_WE(we), .HOST_PTR_WDATA(wd), .HOST_FLY_CLR(fclr), .IRQ_N(irq_n),
      .HALTED(halted), .INSTR_PTR(ptr), .SAVE_PTR(save), .OPERAND(opnd),
      .INT_STATUS(st), .PHASE_LATCHED(ph));
   tcbu_host host_u (.MCLK(MCLK), .IRQ_N(irq_n), .HOST_PTR_WE(we), .HOST_PTR_WDATA(wd));
   // verdict and end of run
   task wrap_up;
   begin
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask
   // compare seen against expected
   task chk(input logic [31:0] seen, exp, input string m);
   begin
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   end
   endtask
   // drive just after the edge
   task tick;
      @(posedge MCLK) #1;
   endtask
   // bounded wait for a condition
   task bounded(input int kind);
      int n;
   begin
      n = 0;
      while ((kind ? irq_n : done) !== 1'b1 && n < 20)
      begin
         np = w0[16] && n == 4;
         tick;
         n++;
      end
      np = 0;
      waited = n;
      if (n == 20)
      begin
         fails++;
         $display("CHECK FAILED %0t wait ran out", $time);
         wrap_up;
      end
   end
   endtask
   // issue one instruction, held until the taking edge
   task run(input logic [31:0] a, b);
   begin
      tick;
      vld = 1;
      w0 = a;
      w1 = b;
      tick;
      vld = 0;
      bounded(0);
   end
   endtask
   initial
   begin
      repeat (2) tick;
      chk({30'h0, halted, irq_n}, 32'h1, "reset");
      RSTN = 1;
      foreach (rows[i])
      begin
         carry = rows[i].c;
         fb = rows[i].f;
         run(rows[i].a, rows[i].b);
         chk(ptr, rows[i].p, "pointer");
         chk(save, rows[i].s, "save");
         chk({31'h0, irq_n}, 32'h1, "request");
      end
      // interrupt without halt: vector kept, fly flag up
      run(32'h98100000, 32'hABCD0001);
      chk(opnd, 32'hABCD0001, "vector");
      chk({23'h0, halted, st}, 32'h4, "fly");
      // second fly with a clear in its deciding cycle: set wins
      tick;
      vld = 1;
      tick;
      vld = 0;
      fclr = 1;
      tick;
      fclr = 0;
      chk({24'h0, st}, 32'h4, "fly set wins");
      fclr = 1;
      tick;
      fclr = 0;
      chk({24'h0, st}, 32'h0, "fly clear");
      // halting interrupt refuses work until resumed
      run(32'h98000000, 32'h0BAD0002);
      chk({30'h0, halted, irq_n}, 32'h2, "halt");
      chk({31'h0, rdy}, 32'h0, "refuse");
      bounded(1);
      chk(ptr, 32'h800, "resume");
      // reserved opcode stops and flags
      run(32'hA0000000, 32'h0);
      chk({24'h0, st}, 32'h1, "illegal");
      bounded(1);
      chk({24'h0, st}, 32'h0, "illegal clear");
      // message out phase, compare after a new phase
      {msg, cd, io} = 3'h6;
      req = 1;
      repeat (4) tick;
      run(32'h860B0000, 32'h9000);
      chk({29'h0, ph}, 32'h6, "phase");
      chk(ptr, 32'h9000, "phase jump");
      chk(waited, 32'h6, "phase wait");
      // target mode tests the attention line
      init = 0;
      atn = 1;
      repeat (4) tick;
      run(32'h800A0000, 32'hA000);
      chk(ptr, 32'hA000, "attention");
      stp = 1;
      tick;
      stp = 0;
      chk(ptr, 32'hA004, "step");
      wrap_up;
   end
endmodule // tb
`default_nettype wire
